// ### rtl/pafo_pkg.sv
// Shared constants for the port alternate-function override block.
package pafo_pkg;

	// Pins per port and ports handled.
	localparam int PORT_WIDTH = 8;
	localparam int PORT_COUNT = 3;
	localparam int PIN_COUNT  = PORT_WIDTH * PORT_COUNT;

	// Port B pin positions of the peripheral functions.
	localparam int PB_SCK   = 7;
	localparam int PB_MISO  = 6;
	localparam int PB_MOSI  = 5;
	localparam int PB_SS    = 4;
	localparam int PB_CMP0  = 3;
	localparam int PB_IRQ2  = 2;
	localparam int PB_CNT1  = 1;
	localparam int PB_CNT0  = 0;

	// Port C pin positions of the test-access and oscillator functions.
	localparam int PC_OSCO  = 7;
	localparam int PC_TDI   = 5;
	localparam int PC_TMS   = 3;
	localparam int PC_TCK   = 2;

	// Port C pins whose pull-up is held on while test access is enabled.
	localparam logic [7:0] JTAG_PULL_MASK = 8'h2c;

	// Value of every registered pad control after reset.
	localparam logic RESET_LEVEL = 1'h0;

endpackage

// ### rtl/pafo_pin_cell.sv
// One pad's override resolution with registered pad controls.
`timescale 1ns/1ps
module pafo_pin_cell (
	input  wire logic ref_clk,
	input  wire logic rst_b,
	input  wire logic pullup_override_en,
	input  wire logic pullup_override_val,
	input  wire logic dir_override_en,
	input  wire logic dir_override_val,
	input  wire logic value_override_en,
	input  wire logic value_override_val,
	input  wire logic input_enable_override_en,
	input  wire logic input_enable_override_val,
	input  wire logic dirBit,
	input  wire logic outLatchBit,
	input  wire logic global_pullup_disable,
	input  wire logic sleepClamp,
	input  wire logic padIn,
	output logic      pullupOn,
	output logic      driveEn,
	output logic      driveVal,
	output logic      inputEn,
	output logic      digital_input_tap
);

	logic next_pullup;
	logic next_driveEn;
	logic next_driveVal;
	logic next_inputEn;

	// Each control takes its override value when enabled, else the port bits (input enable: else the inverted sleep clamp).
	assign next_pullup   = pullup_override_en ? pullup_override_val :
		(~dirBit & outLatchBit & ~global_pullup_disable);
	assign next_driveEn  = dir_override_en ? dir_override_val :
		dirBit;
	assign next_driveVal = value_override_en ? value_override_val :
		outLatchBit;
	assign next_inputEn  = input_enable_override_en ?
		input_enable_override_val : ~sleepClamp;

	// Disabled inputs clamp to ground so a floating pad draws no current.
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			pullupOn          <= pafo_pkg::RESET_LEVEL;
			driveEn           <= pafo_pkg::RESET_LEVEL;
			driveVal          <= pafo_pkg::RESET_LEVEL;
			inputEn           <= pafo_pkg::RESET_LEVEL;
			digital_input_tap <= pafo_pkg::RESET_LEVEL;
		end else begin
			pullupOn          <= next_pullup;
			driveEn           <= next_driveEn;
			driveVal          <= next_driveVal;
			inputEn           <= next_inputEn;
			digital_input_tap <= padIn & next_inputEn;
		end
	end

endmodule

// ### rtl/pafo_port_override.sv
// Alternate-function override logic for ports A, B and C.
`timescale 1ns/1ps
module pafo_port_override (
	input  wire logic       ref_clk,
	input  wire logic       rst_b,
	input  wire logic [7:0] dirA,
	input  wire logic [7:0] dirB,
	input  wire logic [7:0] dirC,
	input  wire logic [7:0] latchA,
	input  wire logic [7:0] latchB,
	input  wire logic [7:0] latchC,
	input  wire logic [7:0] padInA,
	input  wire logic [7:0] padInB,
	input  wire logic [7:0] padInC,
	input  wire logic       global_pullup_disable,
	input  wire logic       sleepClamp,
	input  wire logic       spi_enable_bit,
	input  wire logic       spi_master_select,
	input  wire logic       spiSckOut,
	input  wire logic       spiSlaveOut,
	input  wire logic       spiMasterOut,
	input  wire logic       timer0CompareEnable,
	input  wire logic       timer0_compare_out,
	input  wire logic       ext_irq2_enable,
	input  wire logic       usart_sync_select,
	input  wire logic       usartClockOut,
	input  wire logic       jtagEnable,
	input  wire logic       timer2_async_select,
	output logic [7:0]      pullupA,
	output logic [7:0]      pullupB,
	output logic [7:0]      pullupC,
	output logic [7:0]      driveEnA,
	output logic [7:0]      driveEnB,
	output logic [7:0]      driveEnC,
	output logic [7:0]      driveValA,
	output logic [7:0]      driveValB,
	output logic [7:0]      driveValC,
	output logic [7:0]      inputEnA,
	output logic [7:0]      inputEnB,
	output logic [7:0]      inputEnC,
	output logic [7:0]      tapA,
	output logic [7:0]      tapC,
	output logic            spiSckIn,
	output logic            spiMasterIn,
	output logic            spiSlaveIn,
	output logic            spiSelectIn,
	output logic            ext_irq2_input,
	output logic            timer1_count_in,
	output logic            timer0_count_in,
	output logic            usartClockIn,
	output logic            oscOutSelect
);

	////////////////////////////////////////////////////////////////////////
	// Override sources per port.

	logic       spiSlave;
	logic       spiMaster;
	logic [7:0] aOff;
	logic [7:0] bPullOvrEn;
	logic [7:0] bPullOvrVal;
	logic [7:0] bValOvrEn;
	logic [7:0] bValOvrVal;
	logic [7:0] bInOvrEn;
	logic [7:0] cPullOvrEn;

	// SPI mode split; the forcing only applies while the SPI is enabled.
	assign spiSlave  = spi_enable_bit & ~spi_master_select;
	assign spiMaster = spi_enable_bit & spi_master_select;

	// Port A keeps every override at zero; analog sampling is off-block.
	assign aOff = 8'h00;

	// Forced SPI inputs: slave forces clock, MOSI, select; master forces MISO.
	assign bPullOvrEn = {spiSlave, spiMaster, spiSlave, spiSlave,
		4'h0};
	// A forced input keeps the usual latch-controlled pull-up.
	assign bPullOvrVal = {latchB[7:4] & {4{~global_pullup_disable}},
		4'h0};
	// Driven SPI values, compare output and synchronous USART clock.
	assign bValOvrEn = {spiMaster, spiSlave, spiMaster, 1'h0,
		timer0CompareEnable, 2'h0, usart_sync_select};
	assign bValOvrVal = {spiSckOut, spiSlaveOut, spiMasterOut, 1'h0,
		timer0_compare_out, 2'h0, usartClockOut};
	// Interrupt pin input stays alive through sleep while enabled.
	assign bInOvrEn = {5'h00, ext_irq2_enable, 2'h0};

	// Port C: oscillator detach on bit 7, test access on bits 5, 3, 2.
	assign cPullOvrEn = {timer2_async_select, 1'h0, jtagEnable, 1'h0,
		jtagEnable, jtagEnable, 2'h0};

	////////////////////////////////////////////////////////////////////////
	// Flattened per-pin controls, port A in the low byte.

	logic [23:0] pullOvrEn;
	logic [23:0] pullOvrVal;
	logic [23:0] dirOvrEn;
	logic [23:0] dirOvrVal;
	logic [23:0] valOvrEn;
	logic [23:0] valOvrVal;
	logic [23:0] inOvrEn;
	logic [23:0] inOvrVal;
	logic [23:0] dirAll;
	logic [23:0] latchAll;
	logic [23:0] padAll;
	logic [23:0] pullupAll;
	logic [23:0] driveEnAll;
	logic [23:0] driveValAll;
	logic [23:0] inputEnAll;
	logic [23:0] tapAll;

	// Direction overrides share the pull-up enable; values are always 0.
	assign pullOvrEn  = {cPullOvrEn, bPullOvrEn, aOff};
	assign pullOvrVal = {pafo_pkg::JTAG_PULL_MASK, bPullOvrVal, aOff};
	assign dirOvrEn   = {cPullOvrEn, bPullOvrEn, aOff};
	assign dirOvrVal  = {8'h00, 8'h00, aOff};
	assign valOvrEn   = {8'h00, bValOvrEn, aOff};
	assign valOvrVal  = {8'h00, bValOvrVal, aOff};
	assign inOvrEn    = {cPullOvrEn, bInOvrEn, aOff};
	assign inOvrVal   = {8'h00, bInOvrEn, aOff};

	assign dirAll   = {dirC, dirB, dirA};
	assign latchAll = {latchC, latchB, latchA};
	assign padAll   = {padInC, padInB, padInA};

	// One registered cell per pad.
	genvar gi;
	generate
		for (gi = 0; gi < pafo_pkg::PIN_COUNT; gi = gi + 1) begin : g_pin
			pafo_pin_cell u_cell (
				.ref_clk                   (ref_clk),
				.rst_b                     (rst_b),
				.pullup_override_en        (pullOvrEn[gi]),
				.pullup_override_val       (pullOvrVal[gi]),
				.dir_override_en           (dirOvrEn[gi]),
				.dir_override_val          (dirOvrVal[gi]),
				.value_override_en         (valOvrEn[gi]),
				.value_override_val        (valOvrVal[gi]),
				.input_enable_override_en  (inOvrEn[gi]),
				.input_enable_override_val (inOvrVal[gi]),
				.dirBit                    (dirAll[gi]),
				.outLatchBit               (latchAll[gi]),
				.global_pullup_disable     (global_pullup_disable),
				.sleepClamp                (sleepClamp),
				.padIn                     (padAll[gi]),
				.pullupOn                  (pullupAll[gi]),
				.driveEn                   (driveEnAll[gi]),
				.driveVal                  (driveValAll[gi]),
				.inputEn                   (inputEnAll[gi]),
				.digital_input_tap         (tapAll[gi])
			);
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////
	// Outputs.

	// The test-access pull-ups bypass the reset flops so they survive reset.
	assign pullupA = pullupAll[7:0];
	assign pullupB = pullupAll[15:8];
	assign pullupC = pullupAll[23:16] |
		(pafo_pkg::JTAG_PULL_MASK & {8{jtagEnable}});
	assign driveEnA  = driveEnAll[7:0];
	assign driveEnB  = driveEnAll[15:8];
	assign driveEnC  = driveEnAll[23:16];
	assign driveValA = driveValAll[7:0];
	assign driveValB = driveValAll[15:8];
	assign driveValC = driveValAll[23:16];
	assign inputEnA  = inputEnAll[7:0];
	assign inputEnB  = inputEnAll[15:8];
	assign inputEnC  = inputEnAll[23:16];
	assign tapA      = tapAll[7:0];
	assign tapC      = tapAll[23:16];

	// Port B taps routed to the peripherals; pad settings are untouched.
	assign spiSckIn        = tapAll[8 + pafo_pkg::PB_SCK];
	assign spiMasterIn     = tapAll[8 + pafo_pkg::PB_MISO];
	assign spiSlaveIn      = tapAll[8 + pafo_pkg::PB_MOSI];
	assign spiSelectIn     = tapAll[8 + pafo_pkg::PB_SS];
	assign ext_irq2_input  = tapAll[8 + pafo_pkg::PB_IRQ2];
	assign timer1_count_in = tapAll[8 + pafo_pkg::PB_CNT1];
	assign timer0_count_in = tapAll[8 + pafo_pkg::PB_CNT0];
	assign usartClockIn    = tapAll[8 + pafo_pkg::PB_CNT0];

	// Oscillator amplifier hookup for port C bit 7.
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			oscOutSelect <= pafo_pkg::RESET_LEVEL;
		end else begin
			oscOutSelect <= timer2_async_select;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Checks.

	sequence s_slave_mode;
		spi_enable_bit && !spi_master_select;
	endsequence

	sequence s_master_mode;
		spi_enable_bit && spi_master_select;
	endsequence

	a_pullup_default: assert property (
		@(posedge ref_clk) disable iff (!rst_b)
		1 |=> pullupA == (~$past(dirA) & $past(latchA)
			& {8{~$past(global_pullup_disable)}}))
		else $error("Port A pull-up does not follow port bits.");

	a_dir_override: assert property (
		@(posedge ref_clk) disable iff (!rst_b)
		jtagEnable |=> !driveEnC[5] && !driveEnC[3] && !driveEnC[2])
		else $error("Test access pins still driven.");

	a_value_latch: assert property (
		@(posedge ref_clk) disable iff (!rst_b)
		!timer0CompareEnable |=> driveValB[3] == $past(latchB[3]))
		else $error("Pin level not from output latch.");

	a_input_sleep: assert property (
		@(posedge ref_clk) disable iff (!rst_b)
		1 |=> inputEnA == {8{!$past(sleepClamp)}})
		else $error("Input enable does not follow sleep state.");

	a_porta_plain: assert property (
		@(posedge ref_clk) disable iff (!rst_b)
		1 |=> driveEnA == $past(dirA) && driveValA == $past(latchA))
		else $error("Port A pin was overridden.");

	a_sck_slave: assert property (
		@(posedge ref_clk) disable iff (!rst_b)
		s_slave_mode |=> !driveEnB[7] && !driveEnB[5] && !driveEnB[4])
		else $error("Slave input pin left driven.");

	a_miso_master: assert property (
		@(posedge ref_clk) disable iff (!rst_b)
		s_master_mode |=> !driveEnB[6])
		else $error("Master-in pin left driven.");

	a_master_dir: assert property (
		@(posedge ref_clk) disable iff (!rst_b)
		s_master_mode ##0 dirB[5] |=> driveEnB[5]
			&& driveEnB[4] == $past(dirB[4]))
		else $error("Master-mode direction bits ignored.");

	a_spi_pullup: assert property (
		@(posedge ref_clk) disable iff (!rst_b)
		s_slave_mode |=> pullupB[7] ==
			($past(latchB[7]) && !$past(global_pullup_disable)))
		else $error("Forced input pull-up wrong.");

	a_mosi_drive: assert property (
		@(posedge ref_clk) disable iff (!rst_b)
		s_master_mode |=> driveValB[5] == $past(spiMasterOut))
		else $error("Master data not driven on its pin.");

	a_cmp0_drive: assert property (
		@(posedge ref_clk) disable iff (!rst_b)
		timer0CompareEnable |=> driveValB[3] == $past(timer0_compare_out))
		else $error("Compare output not on its pin.");

	a_irq2_wake: assert property (
		@(posedge ref_clk) disable iff (!rst_b)
		ext_irq2_enable |=> inputEnB[2] && ext_irq2_input == $past(padInB[2]))
		else $error("Interrupt input clamped while enabled.");

	a_count_taps: assert property (
		@(posedge ref_clk) disable iff (!rst_b)
		!sleepClamp |=> timer1_count_in == $past(padInB[1]))
		else $error("Timer1 count input not from pad.");

	a_usart_clock: assert property (
		@(posedge ref_clk) disable iff (!rst_b)
		usart_sync_select |=> driveValB[0] == $past(usartClockOut)
			&& driveEnB[0] == $past(dirB[0]))
		else $error("USART clock pin misrouted.");

	a_jtag_pullup: assert property (
		@(posedge ref_clk) jtagEnable |-> (pullupC & 8'h2c) == 8'h2c)
		else $error("Test access pull-up dropped.");

	a_tosc_detach: assert property (
		@(posedge ref_clk) disable iff (!rst_b)
		timer2_async_select |=> !driveEnC[7] && !pullupC[7] && !inputEnC[7])
		else $error("Oscillator pin still on the port.");

	a_plain_gpio: assert property (
		@(posedge ref_clk) disable iff (!rst_b)
		1 |=> driveEnC[0] == $past(dirC[0])
			&& driveValC[1] == $past(latchC[1]))
		else $error("Plain pin was overridden.");

endmodule

// ### sim/pafo_periph_model.sv
// Peripheral model that feeds driven values into the override block.
`timescale 1ns/1ps
module pafo_periph_model (
	input  wire logic ref_clk,
	input  wire logic rst_b,
	output logic      spiSckOut,
	output logic      spiSlaveOut,
	output logic      spiMasterOut,
	output logic      timer0_compare_out,
	output logic      usartClockOut
);
	logic [2:0] seq;
	////////////////////////////////////////////////////////////////
	// Sources change just after each edge, like real peripheral flops.
	always @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			seq <= 3'h0;
		end else begin
			seq <= #1 seq + 3'h1;
		end
	end
	// Clock and master data run opposite, so a swapped route shows up.
	assign spiSckOut          = seq[0];
	assign spiMasterOut       = ~seq[0];
	assign spiSlaveOut        = seq[1];
	assign timer0_compare_out = seq[2];
	assign usartClockOut      = seq[1] ^ seq[0];
endmodule

// ### sim/pafo_port_override_tb.sv
// Self-checking testbench for the port alternate-function override block.
`timescale 1ns/1ps
module pafo_port_override_tb;
	logic       ref_clk, rst_b, global_pullup_disable, sleepClamp;
	logic       spi_enable_bit, spi_master_select, timer0CompareEnable;
	logic       ext_irq2_enable, usart_sync_select, jtagEnable;
	logic       timer2_async_select, spiSckOut, spiSlaveOut, spiMasterOut;
	logic       timer0_compare_out, usartClockOut;
	logic [7:0] dirA, dirB, dirC, latchA, latchB, latchC;
	logic [7:0] padInA, padInB, padInC, pullupA, pullupB, pullupC;
	logic [7:0] driveEnA, driveEnB, driveEnC, driveValA, driveValB;
	logic [7:0] driveValC, inputEnA, inputEnB, inputEnC, tapA, tapC;
	logic       spiSckIn, spiMasterIn, spiSlaveIn, spiSelectIn;
	logic       ext_irq2_input, timer1_count_in, timer0_count_in;
	logic       usartClockIn, oscOutSelect;
	int         numErrors;
	int         nCompared;
	logic [7:0] pat [4] = '{8'h0f, 8'h33, 8'hc5, 8'h5a};

	pafo_port_override DUT (
		.ref_clk, .rst_b, .dirA, .dirB, .dirC, .latchA, .latchB, .latchC,
		.padInA, .padInB, .padInC, .global_pullup_disable, .sleepClamp,
		.spi_enable_bit, .spi_master_select, .spiSckOut, .spiSlaveOut,
		.spiMasterOut, .timer0CompareEnable, .timer0_compare_out,
		.ext_irq2_enable, .usart_sync_select, .usartClockOut, .jtagEnable,
		.timer2_async_select, .pullupA, .pullupB, .pullupC, .driveEnA,
		.driveEnB, .driveEnC, .driveValA, .driveValB, .driveValC, .inputEnA,
		.inputEnB, .inputEnC, .tapA, .tapC, .spiSckIn, .spiMasterIn,
		.spiSlaveIn, .spiSelectIn, .ext_irq2_input, .timer1_count_in,
		.timer0_count_in, .usartClockIn, .oscOutSelect
	);
	pafo_periph_model periph (.ref_clk, .rst_b, .spiSckOut, .spiSlaveOut,
		.spiMasterOut, .timer0_compare_out, .usartClockOut);

	////////////////////////////////////////////////////////////////
	// Free-running clock, 4 ns period.
	always #2 ref_clk = ~ref_clk;

	// Counts every comparison and reports a mismatch at once.
	task automatic cmp8(input string what, input logic [7:0] exp, got);
		nCompared++;
		if (got !== exp) begin
			numErrors++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask

	// Resolves one port from its overrides; the driven level only matters
	// while the driver is on, so it is masked by the expected enable.
	task automatic chkPort(input logic [7:0] dir, lat, pe, pv, ve, vv, ie,
		iv, gP, gD, gV, gI, output logic [7:0] eI);
		logic [7:0] eD;
		logic [7:0] eP;
		eD = ~pe & dir;
		eP = (pe & pv) | (~pe & ~dir & lat & ~{8{global_pullup_disable}});
		eI = (ie & iv) | (~ie & {8{~sleepClamp}});
		cmp8("pullup", eP, gP);
		cmp8("driveEn", eD, gD);
		cmp8("driveVal", eD & ((ve & vv) | (~ve & lat)), eD & gV);
		cmp8("inputEn", eI, gI);
	endtask

	// One edge: snapshot partner values at the edge, then check all ports.
	task automatic cyc();
		logic       s, m, ck, so, mo, oc, uc;
		logic [7:0] eI, pe, ve, vv;
		@(posedge ref_clk);
		ck = spiSckOut;
		so = spiSlaveOut;
		mo = spiMasterOut;
		oc = timer0_compare_out;
		uc = usartClockOut;
		#1;
		s = spi_enable_bit & ~spi_master_select;
		m = spi_enable_bit & spi_master_select;
		chkPort(dirA, latchA, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
			pullupA, driveEnA, driveValA, inputEnA, eI);
		cmp8("tapA", padInA & eI, tapA);
		pe = {s, m, s, s, 4'h0};
		ve = {m, s, m, 1'b0, timer0CompareEnable, 2'h0, usart_sync_select};
		vv = {ck, so, mo, 1'b0, oc, 2'h0, uc};
		chkPort(dirB, latchB, pe, latchB & ~{8{global_pullup_disable}}, ve,
			vv, {5'h00, ext_irq2_enable, 2'h0}, 8'h04, pullupB, driveEnB,
			driveValB, inputEnB, eI);
		cmp8("tapsB", {padInB[7:4] & eI[7:4],
			padInB[2:0] & eI[2:0], padInB[0] & eI[0]},
			{spiSckIn, spiMasterIn, spiSlaveIn, spiSelectIn, ext_irq2_input,
			timer1_count_in, timer0_count_in, usartClockIn});
		pe = {timer2_async_select, 1'b0, jtagEnable, 1'b0, jtagEnable,
			jtagEnable, 2'h0};
		chkPort(dirC, latchC, pe, 8'h2c, 8'h00, 8'h00, pe, 8'h00, pullupC,
			driveEnC, driveValC, inputEnC, eI);
		cmp8("tapC", padInC & eI, tapC);
		cmp8("oscSel", {7'h00, timer2_async_select},
			{7'h00, oscOutSelect});
	endtask

	////////////////////////////////////////////////////////////////
	// Reset with test access on: its pull-ups must hold, port B pull-ups, port C drivers and port A taps low.
	task automatic tReset();
		@(posedge ref_clk);
		#1;
		rst_b = 1'b0;
		jtagEnable = 1'b1;
		repeat (5) @(posedge ref_clk);
		#1;
		cmp8("rstPullupC", 8'h2c, pullupC);
		cmp8("rstPullupB", 8'h00, pullupB);
		cmp8("rstDriveEnC", 8'h00, driveEnC);
		cmp8("rstTapA", 8'h00, tapA);
		rst_b = 1'b1;
	endtask

	// Plain port use; all three ports get the same direction, latch and pad patterns.
	task automatic tPlain();
		jtagEnable = 1'b0;
		for (int i = 0; i < 4; i++) begin
			{dirA, dirB, dirC} = {3{pat[i]}};
			{latchA, latchB, latchC} = {3{pat[3 - i]}};
			{padInA, padInB, padInC} = {3{~pat[i]}};
			global_pullup_disable = i[0];
			sleepClamp = i[1];
			cyc();
		end
	endtask

	// Both SPI modes, disabled too, with all pins set as outputs in the last four steps.
	task automatic tSpi();
		for (int i = 0; i < 8; i++) begin
			spi_enable_bit = i[2] | i[1];
			spi_master_select = i[0];
			global_pullup_disable = i[1] & i[0];
			sleepClamp = 1'b0;
			dirB = i[2] ? 8'hff : 8'h5a;
			latchB = {5'h1e, i[2:0]};
			padInB = ~padInB;
			cyc();
		end
		spi_enable_bit = 1'b0;
	endtask

	// Compare output, interrupt input in sleep, count and clock pins.
	task automatic tMisc();
		sleepClamp = 1'b1;
		for (int i = 0; i < 8; i++) begin
			timer0CompareEnable = i[0];
			ext_irq2_enable = i[1];
			usart_sync_select = i[2];
			dirB = {6'h02, 1'b0, i[1]};
			latchB = {5'h00, 1'b0, 1'b1, i[0]};
			padInB = 8'hff;
			cyc();
			cyc();
		end
	endtask

	// Oscillator select and test access on port C, both latch senses.
	task automatic tPortC();
		sleepClamp = 1'b0;
		for (int i = 0; i < 4; i++) begin
			jtagEnable = i[0];
			timer2_async_select = i[1];
			{dirC, latchC} = 16'hff00;
			cyc();
			{dirC, latchC} = 16'h00ff;
			cyc();
		end
	endtask

	// Verdict and end of run.
	task automatic finalReport();
		if (numErrors == 0 && nCompared > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	////////////////////////////////////////////////////////////////
	// Main sequence; a second reset after the port C test checks the hold again.
	initial begin
		ref_clk = 1'b0;
		rst_b = 1'b0;
		{global_pullup_disable, sleepClamp, spi_enable_bit} = 3'h0;
		{spi_master_select, timer0CompareEnable, ext_irq2_enable} = 3'h0;
		{usart_sync_select, jtagEnable, timer2_async_select} = 3'h0;
		{dirA, dirB, dirC, latchA, latchB, latchC} = 48'h0;
		{padInA, padInB, padInC} = 24'h5ac396;
		numErrors = 0;
		nCompared = 0;
		tReset();
		tPlain();
		tSpi();
		tMisc();
		tPortC();
		tReset();
		cyc();
		finalReport();
	end

	// Watchdog against a hung run.
	initial begin
		repeat (2000) @(posedge ref_clk);
		numErrors++;
		finalReport();
	end
endmodule
